// ===== src/ipc_integration_ctrl.v
// Integration period control: line cycle count, aperture, auto selection and line sync
//
// Functional notes
// RL1: Aperture equals cycle count over line frequency.
// RL2: 400 Hz line uses 50 Hz in conversion.
// RL3: Writing either setting recomputes the other.
// RL4: Power-up derives aperture from kept cycle count.
// RL5: Line sync waits for positive zero crossing.
// RL6: Auto accepts on, off, once per function.
// RL7: Auto query returns 0 off, 1 on. The code returns 3 when on, with bit 1 mirroring bit 0.
// RL8: Auto picks count by function and resolution.
// RL9: Temperature auto count is 1.
// RL10: AC current auto: 10, 0.02, 0.01, 1.
// RL11: Once enables auto briefly, then disables.
// RL12: Disabling auto keeps last automatic count.
// RL13: Auto overwrites manual count, readback shows it.
// RL14: Auto aperture follows auto cycle-count enable.
// RL15: Valid aperture write clears auto enable.
// RL16: Count range 0.01 to 10, reset 1.
// RL17: Triggers during integration or processing ignored.
// RL18: After once completes, auto query reads disabled.
`include "ipc_map.vh"
module ipc_integration_ctrl (
   input wire pclk, // APB clock, 125 MHz
   input wire presetn, // Asynchronous reset, active low
   input wire psel, // APB select
   input wire penable, // APB access phase
   input wire pwrite, // APB direction, high for write
   input wire [7:0] paddr, // APB byte address
   input wire [31:0] pwdata, // APB write data
   output reg [31:0] prdata, // APB read data
   output reg pready, // APB transfer complete
   output reg pslverr, // APB error answer
   input wire trig_in, // Asynchronous measurement trigger pin
   input wire line_zc_in, // Asynchronous line zero-crossing level, high on positive half
   output reg integrate, // High while the converter integrates
   output reg conv_done // One-cycle pulse when a reading is processed
);
   // Engine and integration states
   localparam E_IDLE = 1'b0;
   localparam E_DIV = 1'b1;
   localparam OP_NPLC = 2'h0;
   localparam OP_APER = 2'h1;
   localparam OP_AUTO = 2'h2;
   localparam OP_SWEEP = 2'h3;
   localparam I_IDLE = 2'h0;
   localparam I_SYNC = 2'h1;
   localparam I_INT = 2'h2;
   localparam I_PROC = 2'h3;
   localparam [31:0] PROC_CYC = `IPC_PROC_CYC;

   reg [10:0] nplc_q [0:6]; // Line cycle count per function, hundredths
   reg [23:0] aper_q [0:6]; // Aperture per function, microseconds
   reg [6:0] auto_q; // Auto cycle-count (and auto aperture) enable per function
   reg [6:0] once_q; // One-shot auto pending per function
   reg [2:0] fsel_q; // Selected function
   reg [2:0] dig_q; // Selected resolution in digits
   reg ares_q; // Auto resolution enabled
   reg line_sync_enable_q; // Integration waits for a zero crossing
   reg [9:0] freq_q; // Line frequency in hertz
   reg eng_q; // Conversion engine state
   reg [1:0] op_q; // Operation the divider works for
   reg [2:0] ef_q; // Function the engine works on
   reg [23:0] aw_q; // Aperture value from a pending write
   reg sweep_q; // Aperture refresh of all functions pending
   reg [2:0] sidx_q; // Function index of the refresh
   reg div_start_q; // Divider start pulse
   reg [31:0] div_num_q; // Divider dividend
   reg [15:0] div_den_q; // Divider divisor
   reg sw_trig_q; // Software trigger pulse
   reg [1:0] ist_q; // Integration state
   reg [31:0] icnt_q; // Integration and processing countdown
   wire div_busy; // Divider running
   wire div_done; // Divider result valid
   wire [31:0] div_quot; // Divider result
   wire [1:0] pin_rise; // Edges of trigger and zero crossing
   wire acc; // APB access phase waiting for an answer
   wire [15:0] feff; // Line frequency used for conversion
   wire [10:0] auto_val; // Automatic count for the selected function
   wire [10:0] wr_nplc; // Count field of a write
   wire [23:0] wr_aper; // Aperture field of a write
   wire trig_any; // Any trigger this cycle
   wire [31:0] aper_cyc; // Selected aperture in clock cycles

   // Line frequency used in the conversion
   function [15:0] ipc_eff_freq;
      input [9:0] f;
      begin
         if (f == `IPC_FREQ_400) begin
            ipc_eff_freq = {6'h00, `IPC_FREQ_SUB}; // RL2
         end else begin
            ipc_eff_freq = {6'h00, f};
         end
      end
   endfunction

   // Automatic count table by function and resolution
   function [10:0] ipc_auto_nplc;
      input [2:0] fn;
      input [2:0] dig;
      input ares;
      begin
         if (fn == `IPC_FN_TEMP) begin
            ipc_auto_nplc = `IPC_NPLC_1; // RL9
         end else if (ares) begin
            ipc_auto_nplc = `IPC_NPLC_1; // RL10
         end else if (fn == `IPC_FN_AC_CURRENT || fn == `IPC_FN_ACV) begin
            case (dig) // RL10
               3'h7: ipc_auto_nplc = `IPC_NPLC_10;
               3'h6: ipc_auto_nplc = `IPC_NPLC_10;
               3'h5: ipc_auto_nplc = `IPC_NPLC_0P02;
               default: ipc_auto_nplc = `IPC_NPLC_0P01;
            endcase
         end else begin
            case (dig)
               3'h7: ipc_auto_nplc = `IPC_NPLC_2;
               3'h6: ipc_auto_nplc = `IPC_NPLC_0P2;
               3'h5: ipc_auto_nplc = `IPC_NPLC_0P02;
               default: ipc_auto_nplc = `IPC_NPLC_0P01;
            endcase
         end
      end
   endfunction

   assign acc = psel & penable & ~pready;
   assign feff = ipc_eff_freq(freq_q);
   assign auto_val = ipc_auto_nplc(fsel_q, dig_q, ares_q); // RL8
   assign wr_nplc = pwdata[10:0];
   assign wr_aper = pwdata[23:0];
   assign trig_any = pin_rise[0] | sw_trig_q;
   assign aper_cyc = aper_q[fsel_q] * `IPC_CLK_MHZ;

   ipc_divider u_div (
      .clk(pclk),
      .rst_n(presetn),
      .start(div_start_q),
      .num(div_num_q),
      .den(div_den_q),
      .busy(div_busy),
      .done(div_done),
      .quot(div_quot)
   );

   ipc_pin_sync u_sync (
      .clk(pclk),
      .rst_n(presetn),
      .pin_in({line_zc_in, trig_in}),
      .rise(pin_rise)
   );

   // Register file and conversion engine share one process so every
   // setting has a single writer; APB waits while a conversion runs
   integer i;
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (i = 0; i < 7; i = i + 1) begin
            nplc_q[i] <= `IPC_NPLC_RST; // RL16
            aper_q[i] <= `IPC_APER_RST;
         end
         auto_q <= 7'h00;
         once_q <= 7'h00;
         fsel_q <= `IPC_FN_AC_CURRENT;
         dig_q <= 3'h6;
         ares_q <= 1'b0;
         line_sync_enable_q <= 1'b0;
         freq_q <= `IPC_FREQ_RST;
         eng_q <= E_IDLE;
         op_q <= OP_NPLC;
         ef_q <= 3'h0;
         aw_q <= 24'h000000;
         sweep_q <= 1'b1; // RL4
         sidx_q <= 3'h0;
         div_start_q <= 1'b0;
         div_num_q <= 32'h00000000;
         div_den_q <= 16'h0001;
         sw_trig_q <= 1'b0;
         prdata <= 32'h00000000;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         div_start_q <= 1'b0;
         sw_trig_q <= 1'b0;
         if (eng_q == E_DIV) begin
            // Store the converted value once the divider finishes
            if (div_done) begin
               eng_q <= E_IDLE;
               case (op_q)
                  OP_APER: begin
                     if (div_quot >= {21'h000000, `IPC_NPLC_MIN} &&
                         div_quot <= {21'h000000, `IPC_NPLC_MAX}) begin
                        nplc_q[ef_q] <= div_quot[10:0]; // RL3
                        aper_q[ef_q] <= aw_q;
                        auto_q[ef_q] <= 1'b0; // RL15
                        once_q[ef_q] <= 1'b0;
                     end else begin
                        pslverr <= 1'b1; // Result out of range, nothing stored
                     end
                     pready <= 1'b1;
                  end
                  OP_NPLC: begin
                     aper_q[ef_q] <= div_quot[23:0]; // RL3 RL1
                     pready <= 1'b1;
                  end
                  OP_AUTO: begin
                     aper_q[ef_q] <= div_quot[23:0]; // RL1
                     if (once_q[ef_q]) begin
                        auto_q[ef_q] <= 1'b0; // RL11 RL18 RL12
                        once_q[ef_q] <= 1'b0;
                     end
                  end
                  default: begin
                     aper_q[ef_q] <= div_quot[23:0]; // RL4
                  end
               endcase
            end
         end else if (sweep_q) begin
            // Refresh apertures from the kept counts, one function at a time
            op_q <= OP_SWEEP;
            ef_q <= sidx_q;
            div_num_q <= {21'h000000, nplc_q[sidx_q]} * {16'h0000, `IPC_US_PER_HCYC}; // RL4
            div_den_q <= feff;
            div_start_q <= 1'b1;
            eng_q <= E_DIV;
            if (sidx_q == `IPC_FN_LAST) begin
               sweep_q <= 1'b0;
               sidx_q <= 3'h0;
            end else begin
               sidx_q <= sidx_q + 3'h1;
            end
         end else if (acc) begin
            // APB access phase
            case (paddr)
               `IPC_OFF_CTRL: begin
                  if (pwrite) begin
                     if (pwdata[`IPC_CTRL_FUNC_LSB +: 3] > `IPC_FN_LAST) begin
                        pslverr <= 1'b1; // No such function
                     end else begin
                        fsel_q <= pwdata[`IPC_CTRL_FUNC_LSB +: 3];
                        dig_q <= pwdata[`IPC_CTRL_DIG_LSB +: 3];
                        ares_q <= pwdata[`IPC_CTRL_ARES_BIT];
                        line_sync_enable_q <= pwdata[`IPC_CTRL_LINE_SYNC_BIT];
                     end
                  end
                  prdata <= {24'h000000, line_sync_enable_q, ares_q, dig_q, fsel_q};
                  pready <= 1'b1;
               end
               `IPC_OFF_NPLC: begin
                  if (!pwrite) begin
                     prdata <= {21'h000000, nplc_q[fsel_q]}; // RL13
                     pready <= 1'b1;
                  end else if (pwdata[31:11] != 21'h000000 || wr_nplc < `IPC_NPLC_MIN ||
                               wr_nplc > `IPC_NPLC_MAX) begin
                     pslverr <= 1'b1; // RL16
                     pready <= 1'b1;
                  end else begin
                     nplc_q[fsel_q] <= wr_nplc; // RL3
                     op_q <= OP_NPLC;
                     ef_q <= fsel_q;
                     div_num_q <= {21'h000000, wr_nplc} * {16'h0000, `IPC_US_PER_HCYC}; // RL1
                     div_den_q <= feff;
                     div_start_q <= 1'b1;
                     eng_q <= E_DIV;
                  end
               end
               `IPC_OFF_APER: begin
                  if (!pwrite) begin
                     prdata <= {8'h00, aper_q[fsel_q]};
                     pready <= 1'b1;
                  end else if (pwdata[31:24] != 8'h00 || wr_aper > `IPC_APER_MAX) begin
                     pslverr <= 1'b1; // Above IPC_APER_MAX, refused whatever the line frequency
                     pready <= 1'b1;
                  end else begin
                     aw_q <= wr_aper;
                     op_q <= OP_APER;
                     ef_q <= fsel_q;
                     div_num_q <= {8'h00, wr_aper} * {16'h0000, feff}; // RL3 RL1
                     div_den_q <= `IPC_US_PER_HCYC;
                     div_start_q <= 1'b1;
                     eng_q <= E_DIV;
                  end
               end
               `IPC_OFF_AUTO: begin
                  if (pwrite) begin
                     case (pwdata[1:0]) // RL6
                        `IPC_AUTO_OFF: begin
                           auto_q[fsel_q] <= 1'b0; // RL12
                           once_q[fsel_q] <= 1'b0;
                        end
                        `IPC_AUTO_ON: begin
                           auto_q[fsel_q] <= 1'b1;
                           once_q[fsel_q] <= 1'b0;
                        end
                        `IPC_AUTO_ONCE: begin
                           auto_q[fsel_q] <= 1'b1; // RL11
                           once_q[fsel_q] <= 1'b1;
                        end
                        default: pslverr <= 1'b1;
                     endcase
                  end
                  // Bit 1 is auto aperture, always equal to bit 0
                  prdata <= {30'h00000000, auto_q[fsel_q], auto_q[fsel_q]}; // RL7 RL14
                  pready <= 1'b1;
               end
               `IPC_OFF_FREQ: begin
                  if (pwrite) begin
                     if (pwdata[31:10] != 22'h000000 || pwdata[9:0] == 10'h000) begin
                        pslverr <= 1'b1; // Zero would divide by zero
                     end else begin
                        freq_q <= pwdata[9:0];
                        sweep_q <= 1'b1; // RL4
                        sidx_q <= 3'h0;
                     end
                  end
                  prdata <= {22'h000000, freq_q};
                  pready <= 1'b1;
               end
               `IPC_OFF_STAT: begin
                  prdata <= {28'h0000000, sweep_q, ist_q == I_PROC, ist_q == I_INT,
                             ist_q == I_SYNC};
                  pready <= 1'b1;
               end
               `IPC_OFF_TRIG: begin
                  if (pwrite) begin
                     sw_trig_q <= pwdata[0];
                  end
                  prdata <= 32'h00000000;
                  pready <= 1'b1;
               end
               default: begin
                  prdata <= 32'h00000000;
                  pslverr <= 1'b1;
                  pready <= 1'b1;
               end
            endcase
         end else if (auto_q[fsel_q] && (once_q[fsel_q] || nplc_q[fsel_q] != auto_val)) begin
            // Auto overwrites the programmed count and refreshes aperture
            nplc_q[fsel_q] <= auto_val; // RL8 RL13
            op_q <= OP_AUTO;
            ef_q <= fsel_q;
            div_num_q <= {21'h000000, auto_val} * {16'h0000, `IPC_US_PER_HCYC};
            div_den_q <= feff;
            div_start_q <= 1'b1;
            eng_q <= E_DIV;
         end
      end
   end

   // Integration sequencer; the period is latched at start so a concurrent
   // setting change only affects the next reading
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ist_q <= I_IDLE;
         icnt_q <= 32'h00000000;
         integrate <= 1'b0;
         conv_done <= 1'b0;
      end else begin
         conv_done <= 1'b0;
         case (ist_q)
            I_IDLE: begin
               if (trig_any) begin
                  icnt_q <= aper_cyc;
                  if (line_sync_enable_q) begin
                     ist_q <= I_SYNC; // RL5
                  end else begin
                     ist_q <= I_INT;
                     integrate <= 1'b1;
                  end
               end
            end
            I_SYNC: begin
               if (pin_rise[1]) begin
                  ist_q <= I_INT; // RL5
                  integrate <= 1'b1;
               end
            end
            I_INT: begin
               // Further triggers fall on the floor until idle again
               if (icnt_q <= 32'h00000001) begin
                  integrate <= 1'b0; // RL17
                  icnt_q <= PROC_CYC;
                  ist_q <= I_PROC;
               end else begin
                  icnt_q <= icnt_q - 32'h00000001;
               end
            end
            default: begin
               if (icnt_q <= 32'h00000001) begin
                  conv_done <= 1'b1;
                  ist_q <= I_IDLE; // RL17
               end else begin
                  icnt_q <= icnt_q - 32'h00000001;
               end
            end
         endcase
      end
   end
endmodule

// ===== src/ipc_map.vh
// Register offsets, field positions, reset values and timing counts for the integration control
`ifndef IPC_MAP_VH
`define IPC_MAP_VH
// Register byte offsets
`define IPC_OFF_CTRL 8'h00
`define IPC_OFF_NPLC 8'h04
`define IPC_OFF_APER 8'h08
`define IPC_OFF_AUTO 8'h0C
`define IPC_OFF_FREQ 8'h10
`define IPC_OFF_STAT 8'h14
`define IPC_OFF_TRIG 8'h18
// Control register fields
`define IPC_CTRL_FUNC_LSB 0
`define IPC_CTRL_DIG_LSB 3
`define IPC_CTRL_ARES_BIT 6
`define IPC_CTRL_LINE_SYNC_BIT 7
// Auto register write codes
`define IPC_AUTO_OFF 2'h0
`define IPC_AUTO_ON 2'h1
`define IPC_AUTO_ONCE 2'h2
// Measurement function codes
`define IPC_FN_AC_CURRENT 3'h0
`define IPC_FN_DCI 3'h1
`define IPC_FN_ACV 3'h2
`define IPC_FN_DCV 3'h3
`define IPC_FN_RES 3'h4
`define IPC_FN_FRES 3'h5
`define IPC_FN_TEMP 3'h6
`define IPC_FN_LAST 3'h6
// Line cycle count held in hundredths of a cycle
`define IPC_NPLC_MIN 11'h001
`define IPC_NPLC_MAX 11'h3E8
`define IPC_NPLC_RST 11'h064
// Fixed line cycle choices in hundredths
`define IPC_NPLC_10 11'h3E8
`define IPC_NPLC_2 11'h0C8
`define IPC_NPLC_0P2 11'h014
`define IPC_NPLC_0P02 11'h002
`define IPC_NPLC_0P01 11'h001
`define IPC_NPLC_1 11'h064
// Aperture held in microseconds
`define IPC_APER_RST 24'h00411B
`define IPC_APER_MAX 24'h0FFFFF
`define IPC_US_PER_HCYC 16'h2710
// Line frequency in hertz
`define IPC_FREQ_RST 10'h03C
`define IPC_FREQ_400 10'h190
`define IPC_FREQ_SUB 10'h032
// Clock and processing time
`define IPC_CLK_MHZ 125
`define IPC_PROC_NS 1000
`define IPC_PROC_CYC ((`IPC_PROC_NS * `IPC_CLK_MHZ + 999) / 1000)
`endif

// ===== src/ipc_divider.v
// Sequential restoring divider used to convert between line cycles and aperture
module ipc_divider (
   input wire clk, // Block clock
   input wire rst_n, // Asynchronous reset, active low
   input wire start, // One-cycle start pulse
   input wire [31:0] num, // Dividend
   input wire [15:0] den, // Divisor, never zero
   output reg busy, // Division running
   output reg done, // One-cycle pulse with a valid quotient
   output reg [31:0] quot // Quotient
);
   reg [32:0] rem_q; // Partial remainder
   reg [5:0] cnt_q; // Bits left to produce
   wire [32:0] trial; // Shifted remainder before subtraction
   wire fits; // Divisor fits into trial

   assign trial = {rem_q[31:0], quot[31]};
   assign fits = (trial >= {17'h00000, den});

   // One quotient bit per cycle; 32 cycles trade speed for a tiny area
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rem_q <= 33'h000000000;
         cnt_q <= 6'h00;
         busy <= 1'b0;
         done <= 1'b0;
         quot <= 32'h00000000;
      end else begin
         done <= 1'b0;
         if (start) begin
            quot <= num;
            rem_q <= 33'h000000000;
            cnt_q <= 6'h20;
            busy <= 1'b1;
         end else if (busy) begin
            // Keep or drop the divisor
            if (fits) begin
               rem_q <= trial - {17'h00000, den};
            end else begin
               rem_q <= trial;
            end
            quot <= {quot[30:0], fits};
            cnt_q <= cnt_q - 6'h01;
            if (cnt_q == 6'h01) begin
               busy <= 1'b0;
               done <= 1'b1;
            end
         end
      end
   end
endmodule

// ===== src/ipc_pin_sync.v
// Two-flop synchronisers with rising-edge detection for the trigger and zero-crossing pins
module ipc_pin_sync (
   input wire clk, // Block clock
   input wire rst_n, // Asynchronous reset, active low
   input wire [1:0] pin_in, // Raw asynchronous pins
   output wire [1:0] rise // One-cycle pulse on each rising edge
);
   reg [1:0] meta_q; // First stage, read only by the second
   reg [1:0] sync_q; // Second stage
   reg [1:0] prev_q; // Delayed copy for edge detection

   genvar g;
   generate
      for (g = 0; g < 2; g = g + 1) begin : g_pin
         // Each pin gets its own chain so a glitch on one never touches the other
         always @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
               meta_q[g] <= 1'b0;
               sync_q[g] <= 1'b0;
               prev_q[g] <= 1'b0;
            end else begin
               meta_q[g] <= pin_in[g];
               sync_q[g] <= meta_q[g];
               prev_q[g] <= sync_q[g];
            end
         end
         assign rise[g] = sync_q[g] & ~prev_q[g];
      end
   endgenerate
endmodule

// ===== verification/ipc_integration_ctrl_props.sv
// Port checks for the integration period control
module ipc_integration_ctrl_props (
   input wire pclk, // Clock
   input wire presetn, // Reset, active low
   input wire psel, // Select
   input wire penable, // Access phase
   input wire pwrite, // Direction
   input wire [7:0] paddr, // Address
   input wire [31:0] pwdata, // Write data
   input wire [31:0] prdata, // Read data
   input wire pready, // Transfer end
   input wire pslverr, // Refusal
   input wire trig_in, // Trigger pin
   input wire line_zc_in, // Line level
   input wire integrate, // Integrating
   input wire conv_done // Reading done
);
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   // Refusal only rides on the ending cycle
   a_err_with_ready: assert property (pslverr |-> pready) else $error("error without ready");
   a_ready_pulse: assert property (pready |=> !pready) else $error("ready held high");
   a_ready_cause: assert property (pready |-> psel && penable) else $error("ready unasked");
   a_done_pulse: assert property (conv_done |=> !conv_done) else $error("done held high");
   // Integration must stay low for the first 8 cycles of the processing phase
   a_proc_quiet: assert property ($fell(integrate) |-> !integrate [*8])
      else $error("integration restarted in processing");
   a_done_bound: assert property ($fell(integrate) |-> ##[1:130] conv_done)
      else $error("no reading after integration");
   a_auto_code: assert property (pready && pwrite && paddr == 8'h0C && pwdata[31:2] == 30'h0
      |-> pslverr == (pwdata[1:0] == 2'h3)) else $error("auto code answer wrong");
   a_count_range: assert property (pready && pwrite && paddr == 8'h04
      && (pwdata == 32'h0 || pwdata > 32'h3E8) |-> pslverr) else $error("bad count taken");
endmodule

bind ipc_integration_ctrl ipc_integration_ctrl_props i_ipc_integration_ctrl_props (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .trig_in(trig_in), .line_zc_in(line_zc_in), .integrate(integrate), .conv_done(conv_done));

// ===== verification/ipc_integration_ctrl_tb.sv
// Self-checking bench for the integration period control
`include "ipc_map.vh"
`define CHK(a, b) begin \
   tests_run++; \
   if ((a) !== (b)) begin \
      num_errors++; \
      $display("FAIL %0t got %0h want %0h", $time, a, b); \
   end \
end
module ipc_integration_ctrl_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, trig_in = 0, line_zc_in = 0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic pready, pslverr, integrate, conv_done;
   int num_errors = 0, tests_run = 0, n, k;
   logic [15:0] lfsr = 16'h0017; // Fixed seed
   logic [7:0] ctl [4] = '{8'h30, 8'h28, 8'h20, 8'h40}; // Digits 6, 5, 4, auto resolution
   logic [31:0] want [4] = '{32'h3E8, 32'h2, 32'h1, 32'h64}; // Expected auto counts
   ipc_integration_ctrl i_ipc_integration_ctrl (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .trig_in(trig_in), .line_zc_in(line_zc_in),
      .integrate(integrate), .conv_done(conv_done));
   initial forever #4 pclk = ~pclk;
   // Next value of the stimulus shift register
   function automatic logic [15:0] next_rand(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   // Aperture in microseconds; a 400 Hz line counts as 50 Hz
   function automatic logic [31:0] aper_of(input int c, input int f);
      return 32'(c * 10000 / (f == 400 ? 50 : f));
   endfunction
   // One APB transfer; waits on ready, bounded only by the watchdog
   task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d, input logic e);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      `CHK(pslverr, e)
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wrap_up();
      $display("Checks %0d, mismatches %0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   // Watchdog against a hung handshake
   initial begin
      repeat (20000) @(posedge pclk);
      num_errors++;
      wrap_up();
   end
   initial begin
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      apb(`IPC_OFF_NPLC, 0, 0, 0);
      `CHK(rd, 32'h64)
      apb(`IPC_OFF_APER, 0, 0, 0);
      `CHK(rd, aper_of(100, 60))
      apb(`IPC_OFF_FREQ, 1, 400, 0);
      apb(`IPC_OFF_FREQ, 0, 0, 0);
      `CHK(rd, 400)
      apb(`IPC_OFF_APER, 0, 0, 0);
      `CHK(rd, aper_of(100, 400))
      apb(`IPC_OFF_FREQ, 1, 60, 0);
      $display("reset and frequency test done");
      // Random counts and apertures, each must recompute the other
      for (k = 0; k < 4; k++) begin
         lfsr = next_rand(lfsr);
         n = lfsr % 1000 + 1;
         apb(`IPC_OFF_NPLC, 1, n, 0);
         apb(`IPC_OFF_APER, 0, 0, 0);
         `CHK(rd, aper_of(n, 60))
         n = lfsr % 16000 + 200;
         apb(`IPC_OFF_APER, 1, n, 0);
         apb(`IPC_OFF_NPLC, 0, 0, 0);
         `CHK(rd, 32'(n * 60 / 10000))
      end
      apb(`IPC_OFF_NPLC, 1, 0, 1);
      apb(`IPC_OFF_NPLC, 1, 1001, 1);
      apb(`IPC_OFF_AUTO, 1, 3, 1);
      apb(`IPC_OFF_CTRL, 1, 7, 1);
      apb(`IPC_OFF_FREQ, 1, 0, 1);
      apb(8'h40, 0, 0, 1);
      $display("conversion test done");
      // Auto table on the AC current function
      apb(`IPC_OFF_AUTO, 1, 1, 0);
      for (k = 0; k < 4; k++) begin
         apb(`IPC_OFF_CTRL, 1, ctl[k], 0);
         repeat (100) @(posedge pclk);
         apb(`IPC_OFF_NPLC, 0, 0, 0);
         `CHK(rd, want[k])
      end
      apb(`IPC_OFF_AUTO, 0, 0, 0);
      `CHK(rd, 32'h3)
      apb(`IPC_OFF_AUTO, 1, 0, 0);
      apb(`IPC_OFF_AUTO, 0, 0, 0);
      `CHK(rd, 32'h0)
      apb(`IPC_OFF_NPLC, 0, 0, 0);
      `CHK(rd, 32'h64)
      apb(`IPC_OFF_AUTO, 1, 1, 0);
      repeat (100) @(posedge pclk);
      apb(`IPC_OFF_APER, 1, 20000, 0);
      apb(`IPC_OFF_AUTO, 0, 0, 0);
      `CHK(rd, 32'h0)
      // One-shot on the DC voltage table at six digits
      apb(`IPC_OFF_CTRL, 1, 8'h33, 0);
      apb(`IPC_OFF_AUTO, 1, 2, 0);
      repeat (100) @(posedge pclk);
      apb(`IPC_OFF_NPLC, 0, 0, 0);
      `CHK(rd, 32'h14)
      // One-shot on temperature
      apb(`IPC_OFF_CTRL, 1, 8'h36, 0);
      apb(`IPC_OFF_CTRL, 0, 0, 0);
      `CHK(rd, 32'h36)
      apb(`IPC_OFF_NPLC, 1, 500, 0);
      apb(`IPC_OFF_AUTO, 1, 2, 0);
      repeat (100) @(posedge pclk);
      apb(`IPC_OFF_NPLC, 0, 0, 0);
      `CHK(rd, 32'h64)
      apb(`IPC_OFF_AUTO, 0, 0, 0);
      `CHK(rd, 32'h0)
      $display("auto test done");
      // Triggered integration of 10 us, a pin trigger inside it is dropped
      apb(`IPC_OFF_CTRL, 1, 8'h30, 0);
      apb(`IPC_OFF_FREQ, 1, 1000, 0);
      apb(`IPC_OFF_NPLC, 1, 1, 0);
      apb(`IPC_OFF_TRIG, 1, 1, 0);
      n = 0;
      while (integrate !== 1'b1 && n < 50) begin
         @(posedge pclk);
         n++;
      end
      n = 0;
      trig_in <= 1'b1;
      while (integrate === 1'b1 && n < 3000) begin
         @(posedge pclk);
         n++;
      end
      trig_in <= 1'b0;
      `CHK(n, 1250)
      // Count the processing time; a pin trigger inside it is dropped too
      n = 0;
      while (conv_done !== 1'b1 && n < 300) begin
         @(posedge pclk);
         n++;
         trig_in <= (n > 20 && n < 60);
      end
      `CHK(n, `IPC_PROC_CYC)
      repeat (200) @(posedge pclk);
      `CHK(integrate, 1'b0)
      // Line sync holds the start until the positive crossing
      apb(`IPC_OFF_CTRL, 1, 8'hB0, 0);
      apb(`IPC_OFF_TRIG, 1, 1, 0);
      repeat (40) @(posedge pclk);
      apb(`IPC_OFF_STAT, 0, 0, 0);
      `CHK(rd, 32'h1)
      `CHK(integrate, 1'b0)
      line_zc_in <= 1'b1;
      repeat (8) @(posedge pclk);
      `CHK(integrate, 1'b1)
      repeat (1500) @(posedge pclk);
      $display("trigger test done");
      wrap_up();
   end
endmodule
